// *** dv/analog_side_model.sv ***
// behavioural comparator cores and the two routed port pins
`timescale 1ns/1ps
module analog_side_model (
    // controls from the block
    input  wire logic [1:0]                   cmp_on,
    input  wire logic                         int_ref_sel,
    input  wire comparator_pkg::pin_drive_s   out_pins,
    // analog levels and external pins
    input  wire logic [15:0]                  vplus,
    input  wire logic [15:0]                  vminus,
    input  wire logic [7:0]                   ref_lvl,
    input  wire logic [3:0]                   pin_ext,
    // towards the block
    output logic [1:0]                        cmp_raw,
    output logic [comparator_pkg::PORT_W-1:0] port_a_in
);
    logic [7:0] p0;
    logic [7:0] p1;
    assign p0 = int_ref_sel ? ref_lvl : vplus[7:0];
    assign p1 = int_ref_sel ? ref_lvl : vplus[15:8];
    // high when plus exceeds, low when off
    assign cmp_raw[0] = cmp_on[0] & (p0 > vminus[7:0]);
    assign cmp_raw[1] = cmp_on[1] & (p1 > vminus[15:8]);
    // undriven routed pins float to pull-up
    assign port_a_in[4] = out_pins.oe[0] ? out_pins.out[0] : 1'b1;
    assign port_a_in[5] = out_pins.oe[1] ? out_pins.out[1] : 1'b1;
    assign port_a_in[3:0] = pin_ext;
endmodule

// *** dv/testbench.sv ***
// register-level tests of the dual comparator control block
`timescale 1ns/1ps
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, cmp_raw, cmp_on;
    logic [2:0]  hsize, comparator_mode_field;
    logic        int_ref_sel, input_switch, sleep, irq_request, wake_request;
    logic [5:0]  port_a_in;
    logic [15:0] vplus, vminus;
    logic [3:0]  pin_ext;
    comparator_pkg::pin_drive_s out_pins;
    int          n_fail, num_checks;
    int          cycles = 0;

    assign hready = hreadyout;
    dual_comparator_control i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cmp_raw(cmp_raw), .cmp_on(cmp_on), .int_ref_sel(int_ref_sel),
        .input_switch(input_switch),
        .comparator_mode_field(comparator_mode_field),
        .port_a_in(port_a_in), .out_pins(out_pins), .sleep(sleep),
        .irq_request(irq_request), .wake_request(wake_request));
    analog_side_model i_model (.cmp_on(cmp_on), .int_ref_sel(int_ref_sel),
        .out_pins(out_pins), .vplus(vplus), .vminus(vminus),
        .ref_lvl(8'h80), .pin_ext(pin_ext), .cmp_raw(cmp_raw),
        .port_a_in(port_a_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= comparator_pkg::HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        ahb(1'b0, a, 32'h00000000);
        check(rd, {24'h000000, exp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    initial begin
        n_fail = 0; num_checks = 0;
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; sleep = 1'b0;
        vplus = 16'h0000; vminus = 16'h0000; pin_ext = 4'hA;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(comparator_pkg::CMP_CTRL_OFF, 8'h07);
        check(cmp_on, 2'b00);
        rdc(comparator_pkg::PORTA_DAT_OFF, 8'h30);
        $display("reset test done");
        for (int m = 0; m < 8; m++) begin
            ahb(1'b1, comparator_pkg::CMP_CTRL_OFF, m | 8);
            idle(1);
            check(int_ref_sel, m == 6);
            check(input_switch, m == 6);
            check(cmp_on, (m == 7) ? 2'b00 : 2'b11);
            check(comparator_mode_field, m[2:0]);
        end
        $display("mode test done");
        ahb(1'b1, comparator_pkg::CMP_CTRL_OFF, 32'h03);
        vplus <= 16'h0080;
        vminus <= 16'h0040;
        idle(1);
        check(out_pins.out, 2'b01);
        ahb(1'b1, comparator_pkg::PORTA_DIR_OFF, 32'hEF);
        idle(1);
        check(out_pins.oe, 2'b01);
        rdc(comparator_pkg::CMP_CTRL_OFF, 8'h43);
        ahb(1'b1, comparator_pkg::CMP_CTRL_OFF, 32'h13);
        idle(4);
        check(out_pins.out, 2'b00);
        rdc(comparator_pkg::CMP_CTRL_OFF, 8'h13);
        ahb(1'b1, comparator_pkg::CMP_CTRL_OFF, 32'hC3);
        idle(4);
        rdc(comparator_pkg::CMP_CTRL_OFF, 8'h43);
        ahb(1'b1, comparator_pkg::CONV1_OFF, 32'h0F);
        rdc(comparator_pkg::PORTA_DAT_OFF, 8'h3A);
        $display("output test done");
        ahb(1'b1, comparator_pkg::INT_CTRL_OFF, 32'hC0);
        ahb(1'b1, comparator_pkg::PEN2_OFF, 32'h40);
        ahb(1'b0, comparator_pkg::CMP_CTRL_OFF, 32'h0);
        ahb(1'b1, comparator_pkg::PFLAG2_OFF, 32'h00);
        idle(4);
        check(irq_request, 1'b0);
        vminus <= 16'h00FF;
        idle(6);
        rdc(comparator_pkg::PFLAG2_OFF, 8'h40);
        check(irq_request, 1'b1);
        ahb(1'b1, comparator_pkg::INT_CTRL_OFF, 32'h40);
        idle(2);
        check(irq_request, 1'b0);
        ahb(1'b1, comparator_pkg::PFLAG2_OFF, 32'h00);
        idle(3);
        rdc(comparator_pkg::PFLAG2_OFF, 8'h40);
        ahb(1'b0, comparator_pkg::CMP_CTRL_OFF, 32'h0);
        ahb(1'b1, comparator_pkg::PFLAG2_OFF, 32'h00);
        idle(3);
        rdc(comparator_pkg::PFLAG2_OFF, 8'h00);
        ahb(1'b1, comparator_pkg::PFLAG2_OFF, 32'h40);
        idle(2);
        rdc(comparator_pkg::PFLAG2_OFF, 8'h40);
        $display("interrupt test done");
        sleep <= 1'b1;
        vminus <= 16'h0040;
        idle(6);
        check(wake_request, 1'b1);
        rdc(comparator_pkg::CMP_CTRL_OFF, 8'h43);
        sleep <= 1'b0;
        $display("sleep test done");
        hresetn <= 1'b0;
        idle(2);
        hresetn <= 1'b1;
        rdc(comparator_pkg::CMP_CTRL_OFF, 8'h07);
        check(cmp_on, 2'b00);
        rdc(comparator_pkg::PFLAG2_OFF, 8'h00);
        rdc(comparator_pkg::PORTA_DAT_OFF, 8'h30);
        $display("second reset test done");
        stop_test();
    end
endmodule

// *** inc/comparator_pkg.sv ***
// constants and state layout for the dual comparator control block
package comparator_pkg;
    // register byte offsets
    localparam logic [7:0] CMP_CTRL_OFF  = 8'h00;
    localparam logic [7:0] INT_CTRL_OFF  = 8'h04;
    localparam logic [7:0] PFLAG2_OFF    = 8'h08;
    localparam logic [7:0] PEN2_OFF      = 8'h0C;
    localparam logic [7:0] PPRI2_OFF     = 8'h10;
    localparam logic [7:0] PORTA_DIR_OFF = 8'h14;
    localparam logic [7:0] CONV1_OFF     = 8'h18;
    localparam logic [7:0] PORTA_DAT_OFF = 8'h1C;
    localparam int         ADDR_W        = 8;

    // comparator_control layout
    localparam int         OUT2_BIT      = 7;
    localparam int         OUT1_BIT      = 6;
    localparam int         INV2_BIT      = 5;
    localparam int         INV1_BIT      = 4;
    localparam int         SWITCH_BIT    = 3;
    localparam logic [7:0] CMP_CTRL_RST  = 8'h07;
    localparam logic [7:0] CMP_CTRL_WMSK = 8'h3F;

    // flag and enable positions
    localparam int         CMP_FLAG_BIT  = 6;
    localparam int         CMP_EN_BIT    = 6;
    localparam int         PERIPH_EN_BIT = 6;
    localparam int         GLOBAL_EN_BIT = 7;

    // port and converter configuration
    localparam int         FIRST_PIN     = 4;
    localparam int         SECOND_PIN    = 5;
    localparam int         PORT_W        = 6;
    localparam logic [7:0] DIR_RST       = 8'hFF;
    localparam logic [7:0] CONV1_RST     = 8'h00;
    localparam logic [3:0] ANALOG_LIMIT  = 4'hB;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [2:0] {
        MODE_RESET_A = 3'b000,
        MODE_ONE_REF = 3'b001,
        MODE_TWO_IND = 3'b010,
        MODE_TWO_OUT = 3'b011,
        MODE_TWO_REF = 3'b100,
        MODE_REF_OUT = 3'b101,
        MODE_MUX_INT = 3'b110,
        MODE_OFF     = 3'b111
    } cmp_mode_e;

    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } pin_drive_s;

    typedef struct packed {
        logic [7:0]        ctrl;
        logic [7:0]        intctl;
        logic              flag;
        logic [7:0]        pen2;
        logic [7:0]        ppri2;
        logic [7:0]        dir;
        logic [7:0]        conv;
        logic [1:0]        sync1;
        logic [1:0]        sync2;
        logic [1:0]        ref_out;
        logic              dph_valid;
        logic              dph_write;
        logic [ADDR_W-1:0] dph_addr;
        logic [31:0]       hrdata;
        logic              irq;
        logic              wake;
        logic [1:0]        pin_oe;
        logic              route;
        logic [1:0]        cmp_on;
        logic              int_ref;
        logic              in_sw;
    } cmp_state_s;
endpackage

// *** rtl/dual_comparator_control.sv ***
// control, status and change detection for two analog comparators
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dual_comparator_control (
    // clock and reset
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // ahb-lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // analog side
    input  wire logic [1:0]                   cmp_raw,
    output logic [1:0]                        cmp_on,
    output logic                              int_ref_sel,
    output logic                              input_switch,
    output logic [2:0]                        comparator_mode_field,
    // port pins
    input  wire logic [comparator_pkg::PORT_W-1:0] port_a_in,
    output comparator_pkg::pin_drive_s        out_pins,
    // system
    input  wire logic                         sleep,
    output logic                              irq_request,
    output logic                              wake_request
);
    comparator_pkg::cmp_state_s s_reg;
    comparator_pkg::cmp_state_s s_next;
    logic [1:0]                 outs;
    logic                       mismatch;
    logic                       ctrl_touch;
    logic                       accept;
    logic [7:0]                 rd;
    logic [1:0]                 inv;

    function automatic logic [comparator_pkg::PORT_W-1:0] analog_mask(
        input logic [3:0] cfg
    );
        logic [comparator_pkg::PORT_W-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i] = (cfg < (comparator_pkg::ANALOG_LIMIT - 4'(i)));
        end
        return m;
    endfunction

    function automatic logic is_route(input logic [2:0] mode);
        return (mode == comparator_pkg::MODE_TWO_OUT) ||
               (mode == comparator_pkg::MODE_REF_OUT);
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.sync1 = cmp_raw;
        s_next.sync2 = s_reg.sync1;
        inv = {s_reg.ctrl[comparator_pkg::INV2_BIT],
               s_reg.ctrl[comparator_pkg::INV1_BIT]};
        outs = s_reg.sync2 ^ inv;
        mismatch = (outs != s_reg.ref_out);
        ctrl_touch = 1'b0;
        accept = hsel && hready && htrans[1];
        s_next.dph_valid = accept;
        s_next.dph_write = hwrite;
        s_next.dph_addr = haddr[comparator_pkg::ADDR_W-1:0];
        rd = '0;
        unique case (haddr[comparator_pkg::ADDR_W-1:0])
            // out2, out1, then stored control bits
            comparator_pkg::CMP_CTRL_OFF: rd = {outs, s_reg.ctrl[5:0]};
            comparator_pkg::INT_CTRL_OFF: rd = s_reg.intctl;
            comparator_pkg::PFLAG2_OFF:
                rd[comparator_pkg::CMP_FLAG_BIT] = s_reg.flag;
            comparator_pkg::PEN2_OFF: rd = s_reg.pen2;
            comparator_pkg::PPRI2_OFF: rd = s_reg.ppri2;
            comparator_pkg::PORTA_DIR_OFF: rd = s_reg.dir;
            comparator_pkg::CONV1_OFF: rd = s_reg.conv;
            comparator_pkg::PORTA_DAT_OFF:
                rd[comparator_pkg::PORT_W-1:0] =
                    port_a_in & ~analog_mask(s_reg.conv[3:0]);
            default: rd = '0;
        endcase
        if (accept && !hwrite) begin
            s_next.hrdata = {24'h000000, rd};
            if (haddr[comparator_pkg::ADDR_W-1:0] ==
                comparator_pkg::CMP_CTRL_OFF) begin
                ctrl_touch = 1'b1;
            end
        end
        if (s_reg.dph_valid && s_reg.dph_write) begin
            unique case (s_reg.dph_addr)
                comparator_pkg::CMP_CTRL_OFF: begin
                    s_next.ctrl = hwdata[7:0] & comparator_pkg::CMP_CTRL_WMSK;
                    ctrl_touch = 1'b1;
                end
                comparator_pkg::INT_CTRL_OFF: s_next.intctl = hwdata[7:0];
                comparator_pkg::PFLAG2_OFF:
                    s_next.flag = hwdata[comparator_pkg::CMP_FLAG_BIT];
                comparator_pkg::PEN2_OFF: s_next.pen2 = hwdata[7:0];
                comparator_pkg::PPRI2_OFF: s_next.ppri2 = hwdata[7:0];
                comparator_pkg::PORTA_DIR_OFF: s_next.dir = hwdata[7:0];
                comparator_pkg::CONV1_OFF: s_next.conv = hwdata[7:0];
                default: s_next.dph_write = hwrite;
            endcase
        end
        if (ctrl_touch) begin
            s_next.ref_out = outs;
        end
        if (mismatch) begin
            s_next.flag = 1'b1;
        end
        s_next.irq = s_next.flag &&
                     s_next.pen2[comparator_pkg::CMP_EN_BIT] &&
                     s_next.intctl[comparator_pkg::PERIPH_EN_BIT] &&
                     s_next.intctl[comparator_pkg::GLOBAL_EN_BIT];
        s_next.wake = sleep && s_next.flag &&
                      s_next.pen2[comparator_pkg::CMP_EN_BIT];
        s_next.pin_oe = {~s_next.dir[comparator_pkg::SECOND_PIN],
                         ~s_next.dir[comparator_pkg::FIRST_PIN]};
        s_next.route = is_route(s_next.ctrl[2:0]);
        // off only by mode, never by sleep
        s_next.cmp_on = (s_next.ctrl[2:0] == comparator_pkg::MODE_OFF)
                        ? 2'b00 : 2'b11;
        // internal reference only in mux mode
        s_next.int_ref = (s_next.ctrl[2:0] == comparator_pkg::MODE_MUX_INT);
        // switch meaningful only in mux mode
        s_next.in_sw = s_next.int_ref &&
                       s_next.ctrl[comparator_pkg::SWITCH_BIT];
    end

    // reset only; sleep leaves state alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg           <= '0;
            s_reg.ctrl      <= comparator_pkg::CMP_CTRL_RST;
            s_reg.dir       <= comparator_pkg::DIR_RST;
            s_reg.conv      <= comparator_pkg::CONV1_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        out_pins.oe  = s_reg.pin_oe;
        out_pins.out = s_reg.route ? (cmp_raw ^ inv) : 2'b00;
    end

    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign hrdata                = s_reg.hrdata;
    assign cmp_on                = s_reg.cmp_on;
    assign int_ref_sel           = s_reg.int_ref;
    assign input_switch          = s_reg.in_sw;
    assign comparator_mode_field = s_reg.ctrl[2:0];
    assign irq_request           = s_reg.irq;
    assign wake_request          = s_reg.wake;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    out_read_only_a: assert property (
        s_reg.dph_valid && s_reg.dph_write &&
        s_reg.dph_addr == comparator_pkg::CMP_CTRL_OFF
        |=> s_reg.ctrl[7:6] == 2'b00)
        else $error("output bits stored in control");
    flag_set_a: assert property (
        mismatch |=> s_reg.flag)
        else $error("mismatch did not set flag");
    irq_gate_a: assert property (
        irq_request |-> s_reg.flag &&
        s_reg.pen2[comparator_pkg::CMP_EN_BIT] &&
        s_reg.intctl[comparator_pkg::GLOBAL_EN_BIT] &&
        s_reg.intctl[comparator_pkg::PERIPH_EN_BIT])
        else $error("request without all enables");
    ref_capture_a: assert property (
        ctrl_touch |=> s_reg.ref_out == $past(outs))
        else $error("reference not captured");
    mode_off_a: assert property (
        s_reg.ctrl[2:0] == comparator_pkg::MODE_OFF |-> cmp_on == 2'b00)
        else $error("comparators on in off mode");
    int_ref_a: assert property (
        int_ref_sel |-> comparator_mode_field ==
        comparator_pkg::MODE_MUX_INT)
        else $error("internal reference outside mux mode");
    analog_zero_a: assert property (
        accept && !hwrite && s_reg.conv[3:0] == 4'h0 &&
        haddr[7:0] == comparator_pkg::PORTA_DAT_OFF
        |=> hrdata[3:0] == 4'h0)
        else $error("analog pin read nonzero");
    pin_oe_a: assert property (
        s_reg.dir[comparator_pkg::FIRST_PIN] |-> !out_pins.oe[0])
        else $error("pin driven while direction is input");
    flag_hold_a: assert property (
        mismatch && s_reg.dph_valid && s_reg.dph_write &&
        s_reg.dph_addr == comparator_pkg::PFLAG2_OFF
        |=> s_reg.flag)
        else $error("persistent mismatch lost flag");
    cmp_run_a: assert property (
        comparator_mode_field != comparator_pkg::MODE_OFF
        |-> cmp_on == 2'b11)
        else $error("active comparator turned off");
    switch_gate_a: assert property (
        input_switch |-> int_ref_sel)
        else $error("input switch outside mux mode");
    route_idle_a: assert property (
        !s_reg.route |-> out_pins.out == 2'b00)
        else $error("pin data without routing mode");
    soft_set_a: assert property (
        s_reg.dph_valid && s_reg.dph_write &&
        s_reg.dph_addr == comparator_pkg::PFLAG2_OFF &&
        hwdata[comparator_pkg::CMP_FLAG_BIT]
        |=> s_reg.flag)
        else $error("software set of flag lost");
    soft_clear_a: assert property (
        s_reg.dph_valid && s_reg.dph_write &&
        s_reg.dph_addr == comparator_pkg::PFLAG2_OFF &&
        !hwdata[comparator_pkg::CMP_FLAG_BIT] && !mismatch
        |=> !s_reg.flag)
        else $error("software clear of flag lost");
    sync_chain_a: assert property (
        1'b1 |=> s_reg.sync2 == $past(s_reg.sync1))
        else $error("synchroniser stage skipped");
    wake_gate_a: assert property (
        wake_request |-> s_reg.flag &&
        s_reg.pen2[comparator_pkg::CMP_EN_BIT])
        else $error("wake without enabled flag");

    change_cov: cover property (mismatch ##1 s_reg.flag ##[1:20] ctrl_touch);
    irq_cov: cover property (irq_request);
    wake_cov: cover property (wake_request);
    route_cov: cover property (s_reg.route && out_pins.oe != 2'b00);
endmodule
